// ---- logic/icn_pkg.sv ----
// Purpose: Shared constants for the input terminal conditioning block
// Assumes: 100 MHz core clock, word-indexed AHB-Lite register map
// Notes: Voltages in 10 mV, frequency in 10 Hz, settings in 0.01 %
package icn_pkg;
	localparam int CLK_NS = 10;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
	localparam int GATE_MS = 100;
	localparam int GATE_CYC = GATE_MS * 1000000 / CLK_NS;
	localparam int DLY_STEP_MS = 100;
	localparam int TAU_STEP_MS = 10;
	localparam int NPT = 24;
	localparam logic [2:0] PULSE_CURVE = 3'h5;
	// Word indices; byte address is four times the index
	localparam logic [9:0] A_CURVE = 10'h000;
	localparam logic [9:0] A_BELOW = 10'h001;
	localparam logic [9:0] A_POL_LO = 10'h002;
	localparam logic [9:0] A_POL_HI = 10'h003;
	localparam logic [9:0] A_DELAY = 10'h004;
	localparam logic [9:0] A_TAU = 10'h008;
	localparam logic [9:0] A_DI = 10'h010;
	localparam logic [9:0] A_FREQ = 10'h011;
	localparam logic [9:0] A_RESULT = 10'h014;
	localparam logic [9:0] A_POINT = 10'h040;
	localparam logic [9:0] A_NONE = 10'h3ff;
	localparam logic [11:0] CURVE_RST = 12'h321;
	localparam logic [11:0] BELOW_RST = 12'h000;
	localparam logic [19:0] POL_RST = 20'h00000;
	localparam logic [15:0] V_MAX = 16'h03e8;
	localparam logic [15:0] F_MAX = 16'h1388;
	localparam logic [15:0] S_MAX = 16'h2710;
	localparam logic [15:0] TAU_MAX = 16'h03e8;
	localparam logic [15:0] TAU_RST = 16'h000a;
	localparam logic [15:0] DLY_MAX = 16'h8ca0;
	typedef logic [3:0][15:0] icn_pts_t;
	localparam icn_pts_t PX2_RST = {V_MAX, V_MAX, V_MAX, 16'h0000};
	localparam icn_pts_t PY2_RST = {S_MAX, S_MAX, S_MAX, 16'h0000};
	localparam icn_pts_t PX4_RST = {V_MAX, 16'h029a, 16'h014d, 16'h0000};
	localparam icn_pts_t PY4_RST = {S_MAX, 16'h1a04, 16'h0d02, 16'h0000};
	localparam icn_pts_t PXP_RST = {F_MAX, F_MAX, F_MAX, 16'h0000};
endpackage : icn_pkg

// ---- logic/icn_ch_if.sv ----
// Purpose: Carries one channel's curve, filter and result
// Assumes: Driven by the top, consumed by one curve mapper
// Notes: Points are ordered by x within a curve
`timescale 1ns/1ps
interface icn_ch_if;
	import icn_pkg::*;
	logic [15:0] x;
	icn_pts_t px;
	icn_pts_t py;
	logic four;
	logic zero_below;
	logic [15:0] tau;
	logic tick;
	logic [15:0] value;
	modport cfg(output x, px, py, four, zero_below, tau, tick, input value);
	modport map(input x, px, py, four, zero_below, tau, tick, output value);
endinterface : icn_ch_if

// ---- logic/icn_curve_map.sv ----
// Purpose: Maps one input through a 2- or 4-point curve and filters it
// Assumes: tick is a one-cycle 1 ms pulse
// Notes: Filter keeps 16 fraction bits so small steps still settle
`timescale 1ns/1ps
module icn_curve_map
	import icn_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Channel
	icn_ch_if.map m
);
	typedef struct packed {
		logic [31:0] acc;
	} icn_map_st_t;
	icn_map_st_t s_q, s_d;
	logic [1:0] seg;
	logic [15:0] xmax, xc, xa, xb;
	logic signed [15:0] ya, yb, target;
	logic signed [31:0] dx, dy, dd, num, diff, steps;

	always_comb begin
		xmax = m.four ? m.px[3] : m.px[1];
		xc = (m.x > xmax) ? xmax : m.x; // [R14]
		seg = 2'h0;
		if (m.four && xc >= m.px[2]) begin
			seg = 2'h2;
		end else if (m.four && xc >= m.px[1]) begin
			seg = 2'h1;
		end
		xa = m.px[seg];
		xb = m.px[seg + 2'h1];
		ya = signed'(m.py[seg]);
		yb = signed'(m.py[seg + 2'h1]);
		dx = $signed({16'h0000, xc - xa});
		dy = 32'(yb) - 32'(ya);
		dd = $signed({16'h0000, xb - xa});
		num = dx * dy;
		target = (dd == 0) ? yb : 16'(32'(ya) + num / dd); // [R15] [R8]
		if (m.x < m.px[0]) begin
			target = m.zero_below ? 16'sh0000 : signed'(m.py[0]); // [R10]
		end
		steps = $signed(32'(m.tau) * 32'(TAU_STEP_MS));
		diff = $signed({target, 16'h0000}) - $signed(s_q.acc);
		s_d = s_q;
		if (m.tau == 16'h0000) begin
			s_d.acc = {target, 16'h0000}; // [R2] [R4] [R6]
		end else if (m.tick) begin
			s_d.acc = s_q.acc + 32'(diff / steps); // [R2] [R4] [R6]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign m.value = s_q.acc[31:16];

	below_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
		(m.x < m.px[0] && m.zero_below && m.tau == 16'h0000) |=> m.value == 16'h0000)
		else $error("below minimum did not give zero");
	below_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
		(m.x < m.px[0] && !m.zero_below && m.tau == 16'h0000) |=> m.value == $past(m.py[0]))
		else $error("below minimum did not give minimum setting");
	clamp_max_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
		(!m.four && m.x > m.px[1] && m.px[1] >= m.px[0]) |-> target == signed'(m.py[1]))
		else $error("input above maximum not clamped");
	filt_pass_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2] [R4] [R6]
		(m.tau == 16'h0000) |=> m.value == $past(target))
		else $error("zero time constant must pass through");
	filt_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2] [R4] [R6]
		(m.tau != 16'h0000 && !m.tick) |=> $stable(s_q.acc))
		else $error("filter moved without a tick");
endmodule : icn_curve_map

// ---- logic/icn_top.sv ----
// Purpose: Input terminal conditioning: analog curves, pulse input, terminals
// Assumes: Inputs synchronous to CORE_CLK; terminal high = closed to common
// Notes: AHB-Lite slave, zero-wait writes, one-wait reads
// Notes on behaviour
// R1: Second analog input maps between two voltage points, 0.00V/10.00V, lower <= upper.
// R2: Second analog input has a filter, time constant 0 to 10.00s, default 0.10s.
// R3: Third two-point curve for third input, 0.00V/10.00V, settings -100.00% to 100.0%.
// R4: Third analog input filter, time constant 0 to 10.00s, default 0.10s.
// R5: Fifth terminal pulse frequency maps between 0.00kHz and 50.00kHz points.
// R6: Mapped pulse frequency has a filter, 0 to 10.00s, default 0.10s.
// R7: Curve select digits pick curve 1..5 for inputs one to three, default 321.
// R8: Curves one to three are two-point, curves four and five four-point.
// R9: One below-minimum digit per analog input, each 0 or 1, default 000.
// R10: Below minimum: digit 0 gives minimum setting, digit 1 gives 0.0%.
// R11: Terminals one to three accept changes after a delay, 0.0s to 3600.0s.
// R12: Ten polarity digits over two five-digit settings; 0 high, 1 low.
// R13: Active high asserts when closed to common; active low when open.
// R14: Input above the maximum point is clamped to it before mapping.
// R15: Between the points the setting is linearly interpolated.
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module icn_top
	import icn_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int GATE_CYCLES = GATE_CYC
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	// Field inputs
	input wire logic [15:0] ANALOG_IN_FIRST,
	input wire logic [15:0] ANALOG_IN_SECOND,
	input wire logic [15:0] ANALOG_IN_THIRD,
	input wire logic [9:0] DI_TERMINAL,
	// Conditioned outputs
	output logic [63:0] SETTINGS,
	output logic [9:0] DI_ASSERTED
);
	typedef struct packed {
		logic hready;
		logic rd_pend;
		logic wr_pend;
		logic [9:0] addr;
		logic [31:0] rdata;
		logic [11:0] curve;
		logic [11:0] below;
		logic [19:0] pol_lo;
		logic [19:0] pol_hi;
		logic [2:0][15:0] delay;
		logic [3:0][15:0] tau;
		logic [5:0][3:0][15:0] px;
		logic [5:0][3:0][15:0] py;
		logic [2:0][22:0] dcnt;
		logic [2:0] acc_in;
		logic [9:0] di;
		logic [31:0] tcnt;
		logic tick;
		logic [31:0] gcnt;
		logic [15:0] ecnt;
		logic [15:0] freq;
		logic pulse_prev;
	} icn_top_st_t;

	icn_top_st_t s_q, s_d;
	logic [3:0][15:0] res;
	logic [2:0][15:0] ain;
	logic pulse_edge;
	logic [31:0] rd_word;

	assign ain = {ANALOG_IN_THIRD, ANALOG_IN_SECOND, ANALOG_IN_FIRST};
	assign pulse_edge = DI_TERMINAL[4] & ~s_q.pulse_prev;

	function automatic logic digits_ok(
		input logic [19:0] v,
		input int nd,
		input logic [3:0] lo,
		input logic [3:0] hi
	);
		logic ok;
		ok = 1'b1;
		for (int k = 0; k < 5; k++) begin
			if (k < nd && (v[4*k +: 4] < lo || v[4*k +: 4] > hi)) begin
				ok = 1'b0;
			end
			if (k >= nd && v[4*k +: 4] != 4'h0) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : digits_ok

	// Read multiplexer; unmapped words read as zero
	always_comb begin
		logic [9:0] off;
		off = s_q.addr - A_POINT;
		rd_word = 32'h0000_0000;
		if (s_q.addr == A_CURVE) begin
			rd_word = {20'h00000, s_q.curve};
		end
		if (s_q.addr == A_BELOW) begin
			rd_word = {20'h00000, s_q.below};
		end
		if (s_q.addr == A_POL_LO) begin
			rd_word = {12'h000, s_q.pol_lo};
		end
		if (s_q.addr == A_POL_HI) begin
			rd_word = {12'h000, s_q.pol_hi};
		end
		if (s_q.addr == A_DI) begin
			rd_word = {22'h000000, s_q.di};
		end
		if (s_q.addr == A_FREQ) begin
			rd_word = {16'h0000, s_q.freq};
		end
		for (int i = 0; i < 3; i++) begin
			if (s_q.addr == A_DELAY + 10'(i)) begin
				rd_word = {16'h0000, s_q.delay[i]};
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (s_q.addr == A_TAU + 10'(i)) begin
				rd_word = {16'h0000, s_q.tau[i]};
			end
			if (s_q.addr == A_RESULT + 10'(i)) begin
				rd_word = {{16{res[i][15]}}, res[i]};
			end
		end
		if (s_q.addr >= A_POINT && off < 10'(NPT)) begin
			rd_word = {s_q.py[off[4:2]][off[1:0]], s_q.px[off[4:2]][off[1:0]]};
		end
	end

	always_comb begin
		logic [9:0] off;
		logic [2:0] c;
		logic [1:0] p;
		logic [1:0] np;
		logic [15:0] vx, lo, hi, lim;
		logic [9:0] polb;
		off = s_q.addr - A_POINT;
		c = off[4:2];
		p = off[1:0];
		np = (c == 3'h3 || c == 3'h4) ? 2'h3 : 2'h1;
		vx = HWDATA[15:0];
		lim = (c == PULSE_CURVE) ? F_MAX : V_MAX;
		lo = 16'h0000;
		hi = lim;
		polb = 10'h000;
		s_d = s_q;
		// Millisecond tick for filters and delays
		s_d.tick = (s_q.tcnt == 32'(TICK_CYCLES - 1));
		s_d.tcnt = s_d.tick ? 32'h0 : s_q.tcnt + 32'h1;
		// Read data phase: one wait state
		if (s_q.rd_pend) begin
			s_d.rdata = rd_word;
			s_d.hready = 1'b1;
			s_d.rd_pend = 1'b0;
		end
		// Write data phase; out-of-range values leave the register as it was
		if (s_q.wr_pend) begin
			s_d.wr_pend = 1'b0;
			if (s_q.addr == A_CURVE && digits_ok({8'h00, HWDATA[11:0]}, 3, 4'h1, 4'h5)) begin
				s_d.curve = HWDATA[11:0]; // [R7]
			end
			if (s_q.addr == A_BELOW && digits_ok({8'h00, HWDATA[11:0]}, 3, 4'h0, 4'h1)) begin
				s_d.below = HWDATA[11:0]; // [R9]
			end
			if (s_q.addr == A_POL_LO && digits_ok(HWDATA[19:0], 5, 4'h0, 4'h1)) begin
				s_d.pol_lo = HWDATA[19:0]; // [R12]
			end
			if (s_q.addr == A_POL_HI && digits_ok(HWDATA[19:0], 5, 4'h0, 4'h1)) begin
				s_d.pol_hi = HWDATA[19:0]; // [R12]
			end
			for (int i = 0; i < 3; i++) begin
				if (s_q.addr == A_DELAY + 10'(i) && vx <= DLY_MAX) begin
					s_d.delay[i] = vx; // [R11]
				end
			end
			for (int i = 0; i < 4; i++) begin
				if (s_q.addr == A_TAU + 10'(i) && vx <= TAU_MAX) begin
					s_d.tau[i] = vx; // [R2] [R4] [R6]
				end
			end
			if (s_q.addr >= A_POINT && off < 10'(NPT)) begin
				// Keep each point between its neighbours within the curve
				if (p != 2'h0 && p <= np) begin
					lo = s_q.px[c][p - 2'h1];
				end
				if (p < np) begin
					hi = s_q.px[c][p + 2'h1];
				end
				if (vx >= lo && vx <= hi) begin
					s_d.px[c][p] = vx; // [R1] [R3] [R5]
				end
				if ($signed(HWDATA[31:16]) >= -$signed(S_MAX) &&
					$signed(HWDATA[31:16]) <= $signed(S_MAX)) begin
					s_d.py[c][p] = HWDATA[31:16]; // [R3]
				end
			end
		end
		// Address phase
		if (HSEL && HREADY && HTRANS[1]) begin
			s_d.addr = (HADDR[31:12] == 20'h00000) ? HADDR[11:2] : A_NONE;
			if (HWRITE) begin
				s_d.wr_pend = 1'b1;
			end else begin
				s_d.rd_pend = 1'b1;
				s_d.hready = 1'b0;
			end
		end
		// Change delay on terminals one to three
		for (int i = 0; i < 3; i++) begin
			if (DI_TERMINAL[i] == s_q.acc_in[i]) begin
				s_d.dcnt[i] = 23'h0;
			end else if (s_q.dcnt[i] >= 23'(s_q.delay[i]) * 23'(DLY_STEP_MS)) begin
				s_d.acc_in[i] = DI_TERMINAL[i]; // [R11]
				s_d.dcnt[i] = 23'h0;
			end else if (s_q.tick) begin
				s_d.dcnt[i] = s_q.dcnt[i] + 23'h1; // [R11]
			end
		end
		// Polarity: closed and active high, or open and active low, asserts
		for (int k = 0; k < 5; k++) begin
			polb[k] = s_q.pol_lo[4*k];
			polb[k + 5] = s_q.pol_hi[4*k];
		end
		for (int i = 0; i < 3; i++) begin
			s_d.di[i] = s_q.acc_in[i] ^ polb[i]; // [R13]
		end
		for (int i = 3; i < 10; i++) begin
			s_d.di[i] = DI_TERMINAL[i] ^ polb[i]; // [R13]
		end
		// Pulse frequency: edges in a 100 ms gate count in 10 Hz units
		s_d.pulse_prev = DI_TERMINAL[4];
		if (s_q.gcnt == 32'(GATE_CYCLES - 1)) begin
			s_d.gcnt = 32'h0;
			s_d.freq = s_q.ecnt + 16'(pulse_edge); // [R5]
			s_d.ecnt = 16'h0000;
		end else begin
			s_d.gcnt = s_q.gcnt + 32'h1;
			if (s_q.ecnt != 16'hffff) begin
				s_d.ecnt = s_q.ecnt + 16'(pulse_edge); // [R5]
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			s_q <= '0;
			s_q.hready <= 1'b1;
			s_q.curve <= CURVE_RST;
			s_q.below <= BELOW_RST;
			s_q.pol_lo <= POL_RST;
			s_q.pol_hi <= POL_RST;
			s_q.tau <= {4{TAU_RST}};
			s_q.px <= {PXP_RST, PX4_RST, PX4_RST, PX2_RST, PX2_RST, PX2_RST};
			s_q.py <= {PY2_RST, PY4_RST, PY4_RST, PY2_RST, PY2_RST, PY2_RST};
		end else begin
			s_q <= s_d;
		end
	end

	// Channels 0..2: analog inputs by selected curve; channel 3: pulse
	for (genvar gi = 0; gi < 4; gi++) begin : g_ch
		icn_ch_if cif();
		logic [2:0] ci;
		if (gi == 3) begin : g_pulse
			assign ci = PULSE_CURVE;
			assign cif.x = s_q.freq;
			assign cif.zero_below = 1'b0;
		end else begin : g_ain
			assign ci = 3'(s_q.curve[4*gi +: 4] - 4'h1); // [R7]
			assign cif.x = ain[gi];
			assign cif.zero_below = s_q.below[4*gi]; // [R9]
		end
		assign cif.px = s_q.px[ci];
		assign cif.py = s_q.py[ci];
		assign cif.four = (ci == 3'h3 || ci == 3'h4); // [R8]
		assign cif.tau = s_q.tau[gi];
		assign cif.tick = s_q.tick;
		assign res[gi] = cif.value;
		icn_curve_map u_map (
			.clk(CORE_CLK),
			.rst_n(RESETN),
			.m(cif.map)
		);
	end

	assign SETTINGS = res;
	assign DI_ASSERTED = s_q.di;
	assign HREADYOUT = s_q.hready;
	assign HRDATA = s_q.rdata;
	assign HRESP = 1'b0;

	sequence rd_req;
		HSEL && HREADY && HTRANS[1] && !HWRITE;
	endsequence
	sequence rd_ans;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	ahb_read_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		rd_req |=> rd_ans)
		else $error("read did not answer after one wait");
	pt_order_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // [R1]
		s_q.px[1][0] <= s_q.px[1][1] && s_q.px[1][1] <= V_MAX)
		else $error("curve 2 points out of order");
	pt_order3_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // [R3]
		s_q.px[2][0] <= s_q.px[2][1] && $signed(s_q.py[2][1]) <= $signed(S_MAX))
		else $error("curve 3 points out of range");
	sel_digit_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // [R7]
		s_q.curve[11:8] >= 4'h1 && s_q.curve[11:8] <= 4'h5)
		else $error("curve select digit out of range");
	pol_map_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // [R12] [R13]
		1'b1 |=> DI_ASSERTED[5] == ($past(DI_TERMINAL[5]) ^ $past(s_q.pol_hi[0])))
		else $error("terminal 6 polarity wrong");
	delay_zero_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // [R11]
		(s_q.delay[0] == 16'h0000 && DI_TERMINAL[0] != s_q.acc_in[0])
		|=> s_q.acc_in[0] == $past(DI_TERMINAL[0]))
		else $error("zero delay not taken at once");
	delay_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // [R11]
		(s_q.delay[0] != 16'h0000 && s_q.dcnt[0] == 23'h0) |=> $stable(s_q.acc_in[0]))
		else $error("delayed terminal changed early");
	freq_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // [R5]
		(s_q.gcnt == 32'(GATE_CYCLES - 1)) |=> s_q.freq == $past(s_q.ecnt) + 16'($past(pulse_edge)))
		else $error("gate count not captured");
	below_digit_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // [R9]
		(s_q.below & 12'heee) == 12'h000)
		else $error("below minimum digit out of range");
	pol_digit_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // [R12]
		(s_q.pol_lo & 20'heeeee) == 20'h00000 && (s_q.pol_hi & 20'heeeee) == 20'h00000)
		else $error("polarity digit out of range");
endmodule : icn_top

// ---- sim/icn_field_model.sv ----
// Purpose: Field side: analog sensors, switch contacts and a pulse source
// Assumes: Levels are settled by the bench between clock edges
// Notes: Terminal bit 1 means closed to input_common
`timescale 1ns/1ps
module icn_field_model (
	// Clock
	input wire logic clk,
	// Field wiring
	output logic [15:0] analog_in_first,
	output logic [15:0] analog_in_second,
	output logic [15:0] analog_in_third,
	output logic [9:0] di
);
	logic [15:0] v1 = 16'h0000;
	logic [15:0] v2 = 16'h0000;
	logic [15:0] v3 = 16'h0000;
	logic [9:0] sw = 10'h000;
	int per = 0;
	int cnt = 0;
	always @(posedge clk) begin
		analog_in_first <= v1;
		analog_in_second <= v2;
		analog_in_third <= v3;
		cnt <= (per == 0 || cnt >= per - 1) ? 0 : cnt + 1;
		// Square wave on the pulse-capable terminal when a period is set
		di <= (per == 0) ? sw : {sw[9:5], (cnt < per / 2), sw[3:0]};
	end
endmodule : icn_field_model

// ---- sim/test_input_terminal_conditioning.sv ----
// Purpose: Self-checking bench for the input conditioning block
// Assumes: Short tick and gate counts; word-indexed register map
// Notes: Filters are set to zero unless a test needs one
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module test_input_terminal_conditioning;
	import icn_pkg::*;
	logic CORE_CLK = 1'b0;
	logic RESETN = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [2:0] HSIZE = 3'h2;
	logic [31:0] HWDATA = 32'h0;
	logic HREADYOUT;
	logic HRESP;
	logic [31:0] HRDATA;
	logic [63:0] SETTINGS;
	logic [9:0] DI_ASSERTED;
	logic [15:0] analog_in_first, analog_in_second, analog_in_third;
	logic [9:0] di;
	logic [31:0] rd;
	int num_errors = 0;
	int tests_run = 0;
	icn_field_model FIELD (.clk(CORE_CLK), .analog_in_first(analog_in_first),
		.analog_in_second(analog_in_second), .analog_in_third(analog_in_third), .di(di));
	icn_top #(.TICK_CYCLES(10), .GATE_CYCLES(200)) DUT (
		.CORE_CLK(CORE_CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
		.ANALOG_IN_FIRST(analog_in_first), .ANALOG_IN_SECOND(analog_in_second),
		.ANALOG_IN_THIRD(analog_in_third), .DI_TERMINAL(di),
		.SETTINGS(SETTINGS), .DI_ASSERTED(DI_ASSERTED));
	initial begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	function automatic logic [31:0] ba(input logic [9:0] i);
		return {20'h0, i, 2'b00};
	endfunction : ba
	task automatic cyc(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask : cyc
	// Address phase held until ready, then data phase held until ready
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= a;
		@(posedge CORE_CLK);
		while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= w ? d : 32'h0;
		@(posedge CORE_CLK);
		while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
		rd = HRDATA;
		`CHK(HRESP, 1'b0)
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rdc
	task automatic t_reset;
		rdc(ba(A_CURVE), 32'h321);
		rdc(ba(A_BELOW), 32'h0);
		rdc(ba(A_POL_LO), 32'h0);
		rdc(ba(A_POL_HI), 32'h0);
		rdc(ba(A_TAU + 10'h1), 32'ha);
		rdc(ba(A_TAU + 10'h2), 32'ha);
		rdc(ba(A_TAU + 10'h3), 32'ha);
		rdc(ba(A_DELAY), 32'h0);
		rdc(32'h114, 32'h271003e8);
		rdc(32'h124, 32'h271003e8);
		rdc(32'h154, 32'h27101388);
		rdc(32'h1000, 32'h0);
		$display("reset values done");
	endtask : t_reset
	task automatic t_map;
		for (int i = 0; i < 4; i++) wr(ba(A_TAU + 10'(i)), 32'h0);
		FIELD.v2 <= 16'h01f4;
		FIELD.v3 <= 16'h04b0;
		cyc(4);
		`CHK(SETTINGS[31:16], 16'h1388)
		`CHK(SETTINGS[47:32], 16'h2710)
		wr(ba(A_TAU), 32'h3e9);
		rdc(ba(A_TAU), 32'h0);
		rdc(ba(A_RESULT + 10'h1), 32'h1388);
		wr(32'h120, 32'hd8ef0000);
		rdc(32'h120, 32'h0);
		wr(32'h120, 32'hd8f00000);
		rdc(32'h120, 32'hd8f00000);
		wr(32'h120, 32'h0);
		$display("mapping done");
	endtask : t_map
	task automatic t_below;
		wr(32'h110, 32'h03e800c8);
		FIELD.v2 <= 16'h0064;
		cyc(4);
		`CHK(SETTINGS[31:16], 16'h03e8)
		wr(ba(A_BELOW), 32'h010);
		wr(ba(A_BELOW), 32'h002);
		rdc(ba(A_BELOW), 32'h010);
		cyc(3);
		`CHK(SETTINGS[31:16], 16'h0000)
		wr(ba(A_BELOW), 32'h0);
		wr(32'h110, 32'h000003e9);
		rdc(32'h110, 32'h000000c8);
		wr(32'h110, 32'h0);
		$display("below minimum done");
	endtask : t_below
	task automatic t_curve;
		wr(ba(A_CURVE), 32'h154);
		wr(ba(A_CURVE), 32'h326);
		rdc(ba(A_CURVE), 32'h154);
		FIELD.v1 <= 16'h014d;
		cyc(4);
		`CHK(SETTINGS[15:0], 16'h0d02)
		`CHK(SETTINGS[31:16], 16'h03e8)
		wr(ba(A_CURVE), 32'h321);
		$display("curve select done");
	endtask : t_curve
	task automatic t_filter;
		wr(ba(A_TAU + 10'h1), 32'h1);
		FIELD.v2 <= 16'h03e8;
		cyc(5);
		`CHK(SETTINGS[31:16] < 16'h2710, 1'b1)
		cyc(1500);
		`CHK(SETTINGS[31:16] >= 16'h2706, 1'b1)
		wr(ba(A_TAU + 10'h1), 32'h0);
		$display("filter done");
	endtask : t_filter
	task automatic t_pulse;
		FIELD.per <= 20;
		cyc(450);
		rdc(ba(A_FREQ), 32'ha);
		`CHK(SETTINGS[63:48], 16'h0014)
		FIELD.per <= 0;
		$display("pulse input done");
	endtask : t_pulse
	task automatic t_pol;
		wr(ba(A_POL_HI), 32'h1);
		cyc(3);
		`CHK(DI_ASSERTED, 10'h020)
		FIELD.sw <= 10'h029;
		cyc(4);
		`CHK(DI_ASSERTED, 10'h009)
		rdc(ba(A_DI), 32'h009);
		wr(ba(A_POL_LO), 32'h2);
		rdc(ba(A_POL_LO), 32'h0);
		wr(ba(A_POL_HI), 32'h0);
		FIELD.sw <= 10'h000;
		$display("polarity done");
	endtask : t_pol
	task automatic t_delay;
		wr(ba(A_DELAY), 32'h1);
		cyc(3);
		FIELD.sw <= 10'h003;
		cyc(5);
		`CHK(DI_ASSERTED, 10'h002)
		cyc(900);
		`CHK(DI_ASSERTED, 10'h002)
		cyc(300);
		`CHK(DI_ASSERTED, 10'h003)
		$display("change delay done");
	endtask : t_delay
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		num_errors++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge CORE_CLK);
		RESETN <= 1'b1;
		t_reset();
		t_map();
		t_below();
		t_curve();
		t_filter();
		t_pulse();
		t_pol();
		t_delay();
		stop_test();
	end
endmodule : test_input_terminal_conditioning
